// *** src/frame_acq_pkg.sv ***
// constants shared by the frame acquisition sequencer
package frame_acq_pkg;
    // register map, word offsets as byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_BURST_LEN = 8'h08;
    localparam logic [7:0] REG_FRAME_PERIOD = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_FRAME_COUNT = 8'h14;
    // control register fields
    localparam int CTRL_CONTINUOUS_BIT = 0;
    localparam int CTRL_BURST_TRIG_ON_BIT = 1;
    localparam int CTRL_FRAME_TRIG_ON_BIT = 2;
    localparam int CTRL_BURST_SRC_LINE_BIT = 3;
    localparam int CTRL_FRAME_SRC_LINE_BIT = 4;
    // command register fields, write one to execute
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_SW_BURST_BIT = 2;
    localparam int CMD_SW_FRAME_BIT = 3;
    // reset values
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [15:0] BURST_LEN_RESET = 16'h0001;
    localparam logic [31:0] FRAME_PERIOD_RESET = 32'h0000_1000;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_BURST = 2'b01,
        ST_WAIT_FRAME = 2'b10,
        ST_IN_FRAME = 2'b11
    } acq_state_e;
endpackage

// *** src/frame_acquisition_sequencer.sv ***
// frame acquisition sequencer: arm, burst window, frame trigger gating
//
// How it works
// - no frame before a start command
// - single mode: one frame, then disarm
// - continuous mode: stay armed until stop
// - after stop, need fresh start
// - burst trigger off: burst start internal
// - burst trigger on: armed waits burst
// - waiting burst: frame triggers ignored
// - burst event opens frame trigger window
// - count frames, burst length closes window
// - frame triggers ignored outside waiting state
// - frame trigger off: internal periodic triggers
// - stop mid-frame finishes frame first
// - source is software command or line 1
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module frame_acquisition_sequencer #(
    parameter int BURST_W = 16
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // trigger input line 1, already synchronous
    input wire logic line1_in,
    // exposure and readout engine
    input wire logic frame_done_in,
    output logic frame_start_out,
    output logic armed_out,
    output logic frame_busy_out
);
    logic wr_ctrl, wr_cmd;
    logic [4:0] ctrl_q;
    logic [BURST_W-1:0] burst_len_q;
    logic [31:0] period_q;
    logic [BURST_W-1:0] burst_cnt_q;
    logic [31:0] timer_q;
    logic [31:0] frame_cnt_q;
    logic line1_q;
    logic line1_rise;
    logic cmd_start, cmd_stop, sw_burst, sw_frame;
    logic burst_ev, frame_ev, timer_ev;
    logic stop_pend_q;
    logic continuous, burst_on, frame_on;
    frame_acq_pkg::acq_state_e state_q, state_d;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == frame_acq_pkg::REG_CTRL);
    assign wr_cmd = reg_wr_in && (reg_addr_in == frame_acq_pkg::REG_CMD);
    assign cmd_start = wr_cmd && reg_wdata_in[frame_acq_pkg::CMD_START_BIT];
    assign cmd_stop = wr_cmd && reg_wdata_in[frame_acq_pkg::CMD_STOP_BIT];
    assign sw_burst = wr_cmd && reg_wdata_in[frame_acq_pkg::CMD_SW_BURST_BIT];
    assign sw_frame = wr_cmd && reg_wdata_in[frame_acq_pkg::CMD_SW_FRAME_BIT];
    assign continuous = ctrl_q[frame_acq_pkg::CTRL_CONTINUOUS_BIT];
    assign burst_on = ctrl_q[frame_acq_pkg::CTRL_BURST_TRIG_ON_BIT];
    assign frame_on = ctrl_q[frame_acq_pkg::CTRL_FRAME_TRIG_ON_BIT];

    // configuration registers
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ctrl_q <= frame_acq_pkg::CTRL_RESET;
            burst_len_q <= BURST_W'(frame_acq_pkg::BURST_LEN_RESET);
            period_q <= frame_acq_pkg::FRAME_PERIOD_RESET;
        end else if (reg_wr_in) begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_in[4:0];
            end
            if (reg_addr_in == frame_acq_pkg::REG_BURST_LEN) begin
                burst_len_q <= reg_wdata_in[BURST_W-1:0];
            end
            if (reg_addr_in == frame_acq_pkg::REG_FRAME_PERIOD) begin
                period_q <= reg_wdata_in;
            end
        end
    end

    // line 1 rising edge detector
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            line1_q <= 1'b0;
        end else begin
            line1_q <= line1_in;
        end
    end
    assign line1_rise = line1_in && !line1_q;

    // trigger source select: software command or line 1 edge
    assign burst_ev = ctrl_q[frame_acq_pkg::CTRL_BURST_SRC_LINE_BIT] ? line1_rise
                      : sw_burst;
    assign frame_ev = !frame_on ? timer_ev
                      : (ctrl_q[frame_acq_pkg::CTRL_FRAME_SRC_LINE_BIT] ? line1_rise
                      : sw_frame);

    // internal frame rate timer, runs only while waiting for a frame
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            timer_q <= 32'h0000_0000;
        end else if (state_q != frame_acq_pkg::ST_WAIT_FRAME || timer_ev) begin
            timer_q <= 32'h0000_0000;
        end else begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end
    assign timer_ev = (state_q == frame_acq_pkg::ST_WAIT_FRAME)
                      && (timer_q + 32'h0000_0001 >= period_q);

    // state transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            frame_acq_pkg::ST_IDLE: begin
                if (cmd_start) begin
                    state_d = burst_on ? frame_acq_pkg::ST_WAIT_BURST
                              : frame_acq_pkg::ST_WAIT_FRAME;
                end
            end
            frame_acq_pkg::ST_WAIT_BURST: begin
                if (cmd_stop) begin
                    state_d = frame_acq_pkg::ST_IDLE;
                end else if (burst_ev) begin
                    state_d = frame_acq_pkg::ST_WAIT_FRAME;
                end
            end
            frame_acq_pkg::ST_WAIT_FRAME: begin
                if (cmd_stop) begin
                    state_d = frame_acq_pkg::ST_IDLE;
                end else if (frame_ev) begin
                    state_d = frame_acq_pkg::ST_IN_FRAME;
                end
            end
            frame_acq_pkg::ST_IN_FRAME: begin
                if (frame_done_in) begin
                    if (stop_pend_q || cmd_stop || !continuous) begin
                        state_d = frame_acq_pkg::ST_IDLE;
                    end else if (burst_on && (burst_cnt_q >= burst_len_q)) begin
                        state_d = frame_acq_pkg::ST_WAIT_BURST;
                    end else begin
                        state_d = frame_acq_pkg::ST_WAIT_FRAME;
                    end
                end
            end
            default: begin
                state_d = frame_acq_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_q <= frame_acq_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // stop held until the running frame completes
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            stop_pend_q <= 1'b0;
        end else if (state_q != frame_acq_pkg::ST_IN_FRAME) begin
            stop_pend_q <= 1'b0;
        end else if (cmd_stop) begin
            stop_pend_q <= 1'b1;
        end
    end

    // burst frame counter
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            burst_cnt_q <= '0;
        end else if (cmd_start || cmd_stop
                     || (state_q == frame_acq_pkg::ST_WAIT_BURST && burst_ev)) begin
            burst_cnt_q <= '0;
        end else if (state_q == frame_acq_pkg::ST_WAIT_FRAME && frame_ev) begin
            burst_cnt_q <= burst_cnt_q + BURST_W'(1);
        end
    end

    // total frames started since reset
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            frame_cnt_q <= 32'h0000_0000;
        end else if (state_q == frame_acq_pkg::ST_WAIT_FRAME && frame_ev && !cmd_stop) begin
            frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
        end
    end

    // outputs to the exposure engine, all registered
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            frame_start_out <= 1'b0;
            armed_out <= 1'b0;
            frame_busy_out <= 1'b0;
        end else begin
            // only the waiting state lets a frame trigger through
            frame_start_out <= (state_q == frame_acq_pkg::ST_WAIT_FRAME)
                               && frame_ev && !cmd_stop;
            armed_out <= (state_d != frame_acq_pkg::ST_IDLE);
            frame_busy_out <= (state_d == frame_acq_pkg::ST_IN_FRAME);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                frame_acq_pkg::REG_CTRL: reg_rdata_out <= {27'h0, ctrl_q};
                frame_acq_pkg::REG_BURST_LEN: reg_rdata_out <= 32'(burst_len_q);
                frame_acq_pkg::REG_FRAME_PERIOD: reg_rdata_out <= period_q;
                frame_acq_pkg::REG_STATUS: begin
                    reg_rdata_out <= {13'h0, stop_pend_q, 2'(state_q), 32'(burst_cnt_q) >> 16 == 0
                                      ? 16'(burst_cnt_q) : 16'hffff};
                end
                frame_acq_pkg::REG_FRAME_COUNT: reg_rdata_out <= frame_cnt_q;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // no frame start unless armed and waiting
    property p_no_frame_idle;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        frame_start_out |-> $past(state_q) == frame_acq_pkg::ST_WAIT_FRAME && frame_busy_out;
    endproperty
    a_no_frame_idle: assert property (p_no_frame_idle)
        else $error("frame start outside waiting state");

    // single mode disarms after frame done
    property p_single;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_q == frame_acq_pkg::ST_IN_FRAME && frame_done_in && !continuous)
            |=> state_q == frame_acq_pkg::ST_IDLE;
    endproperty
    a_single: assert property (p_single)
        else $error("single mode did not disarm");

    // continuous mode stays armed without stop
    property p_cont;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_q == frame_acq_pkg::ST_IN_FRAME && frame_done_in && continuous
            && !cmd_stop && !stop_pend_q) |=> state_q != frame_acq_pkg::ST_IDLE;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode disarmed");

    // stop while waiting disarms at once
    property p_stop;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cmd_stop && state_q != frame_acq_pkg::ST_IN_FRAME) |=> !armed_out;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not disarm");

    // start with burst mode on waits for burst
    property p_arm_burst;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_q == frame_acq_pkg::ST_IDLE && cmd_start)
            |=> state_q == (burst_on ? frame_acq_pkg::ST_WAIT_BURST
                                     : frame_acq_pkg::ST_WAIT_FRAME);
    endproperty
    a_arm_burst: assert property (p_arm_burst)
        else $error("wrong state after start");

    // burst event opens window
    property p_burst_open;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_q == frame_acq_pkg::ST_WAIT_BURST && burst_ev && !cmd_stop)
            |=> state_q == frame_acq_pkg::ST_WAIT_FRAME && burst_cnt_q == '0;
    endproperty
    a_burst_open: assert property (p_burst_open)
        else $error("burst event did not open window");

    // full burst returns to waiting for burst
    property p_burst_close;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_q == frame_acq_pkg::ST_IN_FRAME && frame_done_in && continuous && burst_on
            && !cmd_stop && !stop_pend_q && burst_cnt_q >= burst_len_q)
            |=> state_q == frame_acq_pkg::ST_WAIT_BURST;
    endproperty
    a_burst_close: assert property (p_burst_close)
        else $error("burst did not close");

    // pending stop ends at frame completion
    property p_stop_mid;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (stop_pend_q && frame_done_in) |=> state_q == frame_acq_pkg::ST_IDLE && !armed_out;
    endproperty
    a_stop_mid: assert property (p_stop_mid)
        else $error("stop after frame did not disarm");
endmodule
`default_nettype wire

// *** testbench/exposure_engine_model.sv ***
// behavioural exposure and readout engine facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module exposure_engine_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // frame handshake
    input wire logic start_in,
    input wire logic [7:0] delay_in,
    output logic done_out
);
    logic [7:0] cnt_q;
    // one done pulse delay_in cycles after each start, delay_in at least 2
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt_q == 8'h01);
            if (start_in) begin
                cnt_q <= delay_in;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the frame acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s expected %h seen %h", n, e, g); end end
module testbench;
    localparam logic [7:0] A_CTRL = frame_acq_pkg::REG_CTRL;
    localparam logic [7:0] A_CMD = frame_acq_pkg::REG_CMD;
    localparam logic [7:0] A_STAT = frame_acq_pkg::REG_STATUS;
    localparam logic [31:0] START = 32'h1;
    localparam logic [31:0] STOP = 32'h2;
    localparam logic [31:0] SW_BURST = 32'h4;
    localparam logic [31:0] SW_FRAME = 32'h8;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, line1 = 1'b0;
    logic [7:0] addr = 8'h00, delay = 8'h03;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic done, fstart, armed, busy;
    int fails = 0, compares = 0, frames = 0, f;
    // clock and frame start counter
    always #10 clk = ~clk;
    always @(posedge clk) if (fstart === 1'b1) frames++;
    frame_acquisition_sequencer frame_acquisition_sequencer_inst (.ref_clk_in(clk),
        .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .line1_in(line1), .frame_done_in(done),
        .frame_start_out(fstart), .armed_out(armed), .frame_busy_out(busy));
    exposure_engine_model exposure_engine_model_inst (.clk_in(clk), .rst_n_in(rst_n),
        .start_in(fstart), .delay_in(delay), .done_out(done));
    task results;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // register bus cycles
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task chk_state(input logic [1:0] e);
        rd(A_STAT);
        `CHK("state", e, d[17:16])
    endtask
    task line_pulse;
        @(posedge clk) line1 <= 1'b1;
        @(posedge clk) line1 <= 1'b0;
    endtask
    // bounded waits
    task wait_frames(input int n);
        for (int i = 0; i < 300 && frames < n; i++) @(posedge clk);
        if (frames < n) begin fails++; results(); end
    endtask
    task wait_low(input int which);
        for (int i = 0; i < 300 && (which ? armed : busy) !== 1'b0; i++) @(posedge clk);
        if ((which ? armed : busy) !== 1'b0) begin fails++; results(); end
    endtask
    task t_reset;
        rd(A_CTRL); `CHK("ctrl", 32'h0, d)
        rd(frame_acq_pkg::REG_BURST_LEN); `CHK("burst_len", 32'h1, d)
        rd(frame_acq_pkg::REG_FRAME_PERIOD); `CHK("period", 32'h1000, d)
        rd(8'h3c); `CHK("unmapped", 32'h0, d)
        chk_state(frame_acq_pkg::ST_IDLE);
        wr(A_CTRL, 32'h4); wr(A_CMD, SW_FRAME); repeat (10) @(posedge clk);
        `CHK("frames", 0, frames)
    endtask
    task t_single;
        wr(A_CMD, START); repeat (2) @(posedge clk);
        `CHK("armed", 1'b1, armed)
        chk_state(frame_acq_pkg::ST_WAIT_FRAME);
        f = frames; wr(A_CMD, SW_FRAME); wait_frames(f + 1);
        wait_low(1); `CHK("armed", 1'b0, armed)
        wr(A_CMD, SW_FRAME); repeat (10) @(posedge clk);
        `CHK("frames", f + 1, frames)
    endtask
    task t_burst;
        delay <= 8'h0a; wr(frame_acq_pkg::REG_BURST_LEN, 32'h2);
        wr(A_CTRL, 32'h17); wr(A_CMD, START);
        chk_state(frame_acq_pkg::ST_WAIT_BURST);
        f = frames; line_pulse(); repeat (5) @(posedge clk);
        `CHK("frames", f, frames)
        wr(A_CMD, SW_BURST); chk_state(frame_acq_pkg::ST_WAIT_FRAME);
        `CHK("burst count", 16'h0, d[15:0])
        line_pulse(); wait_frames(f + 1); line_pulse(); wait_low(0);
        `CHK("frames", f + 1, frames)
        line_pulse(); wait_frames(f + 2); wait_low(0);
        chk_state(frame_acq_pkg::ST_WAIT_BURST);
        `CHK("armed", 1'b1, armed)
        wr(A_CMD, SW_BURST); rd(A_STAT); `CHK("burst count", 16'h0, d[15:0])
        wr(A_CMD, STOP); repeat (2) @(posedge clk); `CHK("armed", 1'b0, armed)
    endtask
    // burst start from line 1, frame start from software only
    task t_line_burst;
        wr(A_CTRL, 32'hf); wr(A_CMD, START); f = frames;
        wr(A_CMD, SW_BURST); chk_state(frame_acq_pkg::ST_WAIT_BURST);
        line_pulse(); chk_state(frame_acq_pkg::ST_WAIT_FRAME);
        line_pulse(); repeat (5) @(posedge clk);
        `CHK("frames", f, frames)
        wr(A_CMD, STOP); repeat (2) @(posedge clk); `CHK("armed", 1'b0, armed)
    endtask
    task t_stop_mid;
        delay <= 8'h28; wr(A_CTRL, 32'h5); wr(A_CMD, START);
        f = frames; wr(A_CMD, SW_FRAME); wait_frames(f + 1);
        wr(A_CMD, STOP); repeat (2) @(posedge clk);
        `CHK("armed", 1'b1, armed)
        `CHK("busy", 1'b1, busy)
        rd(A_STAT); `CHK("stop pending", 1'b1, d[18])
        wait_low(1); `CHK("busy", 1'b0, busy)
        wr(A_CMD, SW_FRAME); repeat (10) @(posedge clk);
        `CHK("frames", f + 1, frames)
    endtask
    task t_internal;
        delay <= 8'h02; wr(frame_acq_pkg::REG_FRAME_PERIOD, 32'h4);
        wr(A_CTRL, 32'h1); f = frames; wr(A_CMD, START);
        wait_frames(f + 3);
        `CHK("armed", 1'b1, armed)
        wr(A_CMD, STOP); wait_low(1); `CHK("armed", 1'b0, armed)
        rd(frame_acq_pkg::REG_FRAME_COUNT); `CHK("frame count", frames, d)
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_burst();
        t_line_burst();
        t_stop_mid();
        t_internal();
        results();
    end
endmodule
`default_nettype wire
